// file: clcd_regs.svh
`ifndef CLCD_REGS_SVH
`define CLCD_REGS_SVH

// ****************************************************************
// Timing and sizes
// ****************************************************************
`define CLCD_FRAME_DIV 2304
`define CLCD_BUSY_CYCLES 16
`define CLCD_BLINK_FRAMES 6'h20
`define CLCD_TEXT_DEPTH 80
`define CLCD_GLYPH_DEPTH 128
`define CLCD_ROWS 32
`define CLCD_ROWS_HALF 16
`define CLCD_BIAS_MUX16 3'h5
`define CLCD_BIAS_MUX32 3'h6
`define CLCD_BLANK_CODE 8'h20
`define CLCD_USER_GLYPH_COLUMN 4'h0

// ****************************************************************
// Text memory address map
// ****************************************************************
`define CLCD_ADDR_ZERO 7'h00
`define CLCD_ONE_END 7'h4F
`define CLCD_TWO_L1_END 7'h27
`define CLCD_TWO_L2_START 7'h40
`define CLCD_TWO_L2_END 7'h67
`define CLCD_FOUR_L1_END 7'h13
`define CLCD_FOUR_L2_START 7'h20
`define CLCD_FOUR_L2_END 7'h33
`define CLCD_FOUR_L3_START 7'h40
`define CLCD_FOUR_L3_END 7'h53
`define CLCD_FOUR_L4_START 7'h60
`define CLCD_FOUR_L4_END 7'h73
`define CLCD_FOUR_LINE_LEN 7'h14
`define CLCD_TWO_LINE_LEN 7'h28

// ****************************************************************
// Instruction codes and fields
// ****************************************************************
`define CLCD_CMD_CLEAR 8'h01
`define CLCD_CMD_HOME 8'h02
`define CLCD_CLS_ENTRY 6'h01
`define CLCD_CLS_DISPLAY 5'h01
`define CLCD_CLS_FUNCTION 3'h1
`define CLCD_CLS_GLYPH_ADDR 2'h1
`define CLCD_ENTRY_UP_BIT 1
`define CLCD_DISP_ON_BIT 2
`define CLCD_DISP_CURSOR_BIT 1
`define CLCD_DISP_BLINK_BIT 0
`define CLCD_FUNC_LINES_HI 3
`define CLCD_FUNC_LINES_LO 2
`define CLCD_FUNC_GEN_BIT 0

`endif

// file: clcd_pkg.sv
`include "clcd_regs.svh"

package clcd_pkg;

  typedef struct packed {
    logic register_select;
    logic read_select;
    logic strobe;
    logic [7:0] data;
  } clcd_bus_in_type;

  typedef enum logic [1:0] {
    LINES_ONE,
    LINES_TWO,
    LINES_FOUR
  } clcd_lines_type;

  typedef enum logic [1:0] {
    ST_SWEEP,
    ST_WAIT,
    ST_IDLE
  } clcd_state_type;

endpackage

// file: clcd_frame_timer.sv
`timescale 1ns/1ns
`include "clcd_regs.svh"

module clcd_frame_timer #(
  parameter int FRAME_DIV = `CLCD_FRAME_DIV,
  parameter int ROWS = `CLCD_ROWS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic one_line_i,
  output logic frame_tick_o,
  output logic [ROWS-1:0] row_select_o
);

  localparam int PERIOD_16 = FRAME_DIV / (ROWS / 2);
  localparam int PERIOD_32 = FRAME_DIV / ROWS;

  logic [11:0] cyc;
  logic [11:0] next_cyc;
  logic [11:0] row_cyc;
  logic [11:0] next_row_cyc;
  logic [4:0] row;
  logic [4:0] next_row;
  logic tick;
  logic next_tick;
  logic [11:0] period;

  // ****************************************************************
  // Frame and row counters
  // ****************************************************************
  always_comb begin
    period = one_line_i ? 12'(PERIOD_16) : 12'(PERIOD_32);
    next_tick = 1'b0;
    next_cyc = cyc + 12'h001;
    next_row_cyc = row_cyc + 12'h001;
    next_row = row;
    if (row_cyc >= period - 12'h001) begin
      next_row_cyc = 12'h000;
      next_row = row + 5'h01;
      if (one_line_i && row == 5'(ROWS / 2 - 1)) begin
        next_row = 5'h00;
      end
    end
    // The frame is the clock divided by FRAME_DIV in both multiplex modes.
    if (cyc == 12'(FRAME_DIV - 1)) begin
      next_cyc = 12'h000;
      next_tick = 1'b1;
      next_row_cyc = 12'h000;
      next_row = 5'h00;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cyc <= 12'h000;
      row_cyc <= 12'h000;
      row <= 5'h00;
      tick <= 1'b0;
    end else begin
      cyc <= next_cyc;
      row_cyc <= next_row_cyc;
      row <= next_row;
      tick <= next_tick;
    end
  end

  // ****************************************************************
  // Row drive
  // ****************************************************************
  always_comb begin
    row_select_o = '0;
    row_select_o[row] = 1'b1;
    // Paired rows let the board tie both halves together for more drive.
    if (one_line_i) begin
      row_select_o[row + 5'(ROWS / 2)] = 1'b1;
    end
  end

  assign frame_tick_o = tick;

endmodule

// file: clcd_core.sv
`timescale 1ns/1ns
`include "clcd_regs.svh"

module clcd_core
  import clcd_pkg::*;
#(
  parameter int BUSY_CYCLES = `CLCD_BUSY_CYCLES,
  parameter int FRAME_DIV = `CLCD_FRAME_DIV
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire clcd_bus_in_type bus_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  output logic busy_o,
  output logic generator_negative_o,
  output logic [2:0] bias_levels_o,
  output logic [`CLCD_ROWS-1:0] row_select_o,
  output logic frame_tick_o,
  output logic [6:0] cursor_addr_o,
  output logic cursor_on_o,
  output logic cursor_blink_o,
  output logic display_on_o,
  output logic [6:0] scan_index_o,
  output logic [7:0] scan_code_o,
  output logic scan_user_glyph_o
);

  // ****************************************************************
  // Address helpers
  // ****************************************************************
  function automatic logic text_addr_ok(input logic [6:0] a, input clcd_lines_type l);
    case (l)
      LINES_ONE: text_addr_ok = (a <= `CLCD_ONE_END);
      LINES_TWO: text_addr_ok = (a <= `CLCD_TWO_L1_END) ||
        (a >= `CLCD_TWO_L2_START && a <= `CLCD_TWO_L2_END);
      default: text_addr_ok = (a[4:0] < 5'(`CLCD_FOUR_LINE_LEN));
    endcase
  endfunction

  // Folds the sparse line ranges onto the 80 stored places.
  function automatic logic [6:0] text_index(input logic [6:0] a, input clcd_lines_type l);
    case (l)
      LINES_ONE: text_index = a;
      LINES_TWO: text_index = a[6] ? (a - `CLCD_TWO_L2_START + `CLCD_TWO_LINE_LEN) : a;
      default: text_index = 7'(a[6:5] * `CLCD_FOUR_LINE_LEN) + {2'h0, a[4:0]};
    endcase
  endfunction

  function automatic logic [6:0] step_addr(input logic [6:0] a, input logic glyph,
                                           input clcd_lines_type l, input logic up);
    logic [1:0] nbr_line;
    logic [6:0] n;
    nbr_line = up ? a[6:5] + 2'h1 : a[6:5] - 2'h1;
    n = up ? a + 7'h01 : a - 7'h01;
    if (!glyph && text_addr_ok(a, l) && !text_addr_ok(n, l)) begin
      case (l)
        LINES_ONE: n = up ? `CLCD_ADDR_ZERO : `CLCD_ONE_END;
        LINES_TWO: n = up ? (a[6] ? `CLCD_ADDR_ZERO : `CLCD_TWO_L2_START) :
          (a[6] ? `CLCD_TWO_L1_END : `CLCD_TWO_L2_END);
        default: n = up ? {nbr_line, 5'(`CLCD_ADDR_ZERO)} : {nbr_line, 5'(`CLCD_FOUR_L1_END)};
      endcase
    end
    step_addr = n;
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  clcd_bus_in_type pin_meta, pin;
  clcd_state_type state, next_state;
  logic [7:0] busy_cnt, next_busy_cnt;
  logic [6:0] sweep_idx, next_sweep_idx;
  logic [6:0] ac, next_ac;
  logic glyph_mode, next_glyph_mode;
  logic step_up, next_step_up;
  clcd_lines_type lines, next_lines;
  logic gen_negative, next_gen_negative;
  logic disp_on, next_disp_on;
  logic cursor_en, next_cursor_en;
  logic blink_en, next_blink_en;
  logic [7:0] data_register, next_data_register;
  logic [5:0] blink_cnt, next_blink_cnt;
  logic blink_phase, next_blink_phase;
  logic [6:0] scan_idx, next_scan_idx;
  logic [7:0] next_data_o, next_scan_code;
  logic [7:0] text_mem [`CLCD_TEXT_DEPTH];
  logic [7:0] glyph_mem [`CLCD_GLYPH_DEPTH];
  logic text_we, glyph_we;
  logic [6:0] wr_idx;
  logic [7:0] wr_data;
  logic strobe_d, rise, fall, busy;
  logic [7:0] rd_byte, cmd;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_meta <= '0;
      pin <= '0;
      strobe_d <= 1'b0;
    end else begin
      pin_meta <= bus_i;
      pin <= pin_meta;
      strobe_d <= pin.strobe;
    end
  end

  assign rise = pin.strobe & ~strobe_d;
  assign fall = ~pin.strobe & strobe_d;
  assign busy = (state != ST_IDLE);
  assign cmd = pin.data;
  assign rd_byte = glyph_mode ? glyph_mem[ac] :
    (text_addr_ok(ac, lines) ? text_mem[text_index(ac, lines)] : 8'h00);

  // ****************************************************************
  // Control next state
  // ****************************************************************
  always_comb begin
    next_state = state;
    next_busy_cnt = busy_cnt;
    next_sweep_idx = sweep_idx;
    next_ac = ac;
    next_glyph_mode = glyph_mode;
    next_step_up = step_up;
    next_lines = lines;
    next_gen_negative = gen_negative;
    next_disp_on = disp_on;
    next_cursor_en = cursor_en;
    next_blink_en = blink_en;
    next_data_register = data_register;
    next_data_o = data_o;
    text_we = 1'b0;
    glyph_we = 1'b0;
    wr_idx = 7'h00;
    wr_data = 8'h00;
    case (state)
      ST_SWEEP: begin
        // Blanking every place at power-up needs no host help.
        text_we = 1'b1;
        wr_idx = sweep_idx;
        wr_data = `CLCD_BLANK_CODE;
        next_sweep_idx = sweep_idx + 7'h01;
        if (sweep_idx == 7'(`CLCD_TEXT_DEPTH - 1)) begin
          next_sweep_idx = 7'h00;
          next_state = ST_IDLE;
          next_ac = `CLCD_ADDR_ZERO;
          next_glyph_mode = 1'b0;
          next_step_up = 1'b1;
        end
      end
      ST_WAIT: begin
        next_busy_cnt = busy_cnt - 8'h01;
        if (busy_cnt <= 8'h01) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (rise && pin.read_select) begin
      if (pin.register_select) begin
        next_data_register = rd_byte;
        next_data_o = rd_byte;
      end else begin
        next_data_o = {busy, ac};
      end
    end
    if (fall && pin.read_select && pin.register_select) begin
      next_ac = step_addr(ac, glyph_mode, lines, step_up);
    end else if (fall && !pin.read_select && !busy) begin
      next_state = ST_WAIT;
      next_busy_cnt = 8'(BUSY_CYCLES);
      if (pin.register_select) begin
        next_data_register = cmd;
        wr_data = cmd;
        if (glyph_mode) begin
          glyph_we = 1'b1;
          wr_idx = ac;
        end else begin
          // Places off the panel hold no data: writes there are dropped and reads give 00.
          text_we = text_addr_ok(ac, lines);
          wr_idx = text_index(ac, lines);
        end
        next_ac = step_addr(ac, glyph_mode, lines, step_up);
      end else begin
        // Instruction writes only steer state, nothing reads them back.
        if (cmd[7]) begin
          next_ac = cmd[6:0];
          next_glyph_mode = 1'b0;
        end else if (cmd[7:6] == `CLCD_CLS_GLYPH_ADDR) begin
          next_ac = {1'b0, cmd[5:0]};
          next_glyph_mode = 1'b1;
        end else if (cmd[7:5] == `CLCD_CLS_FUNCTION) begin
          case (cmd[`CLCD_FUNC_LINES_HI:`CLCD_FUNC_LINES_LO])
            2'h0: next_lines = LINES_ONE;
            2'h1: next_lines = LINES_TWO;
            default: next_lines = LINES_FOUR;
          endcase
          next_gen_negative = cmd[`CLCD_FUNC_GEN_BIT];
        end else if (cmd[7:3] == `CLCD_CLS_DISPLAY) begin
          next_disp_on = cmd[`CLCD_DISP_ON_BIT];
          next_cursor_en = cmd[`CLCD_DISP_CURSOR_BIT];
          next_blink_en = cmd[`CLCD_DISP_BLINK_BIT];
        end else if (cmd[7:2] == `CLCD_CLS_ENTRY) begin
          next_step_up = cmd[`CLCD_ENTRY_UP_BIT];
        end else if (cmd == `CLCD_CMD_HOME) begin
          next_ac = `CLCD_ADDR_ZERO;
          next_glyph_mode = 1'b0;
        end else if (cmd == `CLCD_CMD_CLEAR) begin
          next_state = ST_SWEEP;
        end
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_SWEEP;
      busy_cnt <= 8'h00;
      sweep_idx <= 7'h00;
      ac <= 7'h00;
      glyph_mode <= 1'b0;
      step_up <= 1'b1;
      lines <= LINES_ONE;
      gen_negative <= 1'b0;
      disp_on <= 1'b0;
      cursor_en <= 1'b0;
      blink_en <= 1'b0;
      data_register <= 8'h00;
      data_o <= 8'h00;
    end else begin
      state <= next_state;
      busy_cnt <= next_busy_cnt;
      sweep_idx <= next_sweep_idx;
      ac <= next_ac;
      glyph_mode <= next_glyph_mode;
      step_up <= next_step_up;
      lines <= next_lines;
      gen_negative <= next_gen_negative;
      disp_on <= next_disp_on;
      cursor_en <= next_cursor_en;
      blink_en <= next_blink_en;
      data_register <= next_data_register;
      data_o <= next_data_o;
    end
  end

  // Memories have no reset; the power-up sweep gives text a known value.
  always_ff @(posedge clk_i) begin
    if (text_we) begin
      text_mem[wr_idx] <= wr_data;
    end
    if (glyph_we) begin
      glyph_mem[wr_idx] <= wr_data;
    end
  end

  // ****************************************************************
  // Display scan and cursor
  // ****************************************************************
  always_comb begin
    next_scan_idx = (scan_idx == 7'(`CLCD_TEXT_DEPTH - 1)) ? 7'h00 : scan_idx + 7'h01;
    next_scan_code = (state == ST_SWEEP) ? `CLCD_BLANK_CODE : text_mem[scan_idx];
    next_blink_cnt = blink_cnt;
    next_blink_phase = blink_phase;
    if (frame_tick_o) begin
      next_blink_cnt = blink_cnt + 6'h01;
      if (blink_cnt == `CLCD_BLINK_FRAMES - 6'h01) begin
        next_blink_cnt = 6'h00;
        next_blink_phase = ~blink_phase;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      scan_idx <= 7'h00;
      scan_index_o <= 7'h00;
      scan_code_o <= 8'h00;
      blink_cnt <= 6'h00;
      blink_phase <= 1'b0;
    end else begin
      scan_idx <= next_scan_idx;
      scan_index_o <= scan_idx;
      scan_code_o <= next_scan_code;
      blink_cnt <= next_blink_cnt;
      blink_phase <= next_blink_phase;
    end
  end

  clcd_frame_timer #(.FRAME_DIV(FRAME_DIV), .ROWS(`CLCD_ROWS)) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .one_line_i(lines == LINES_ONE),
    .frame_tick_o(frame_tick_o),
    .row_select_o(row_select_o)
  );

  // Codes in the first column pick a user glyph; the rest go to the ROM.
  assign scan_user_glyph_o = (scan_code_o[7:4] == `CLCD_USER_GLYPH_COLUMN);
  assign data_oe_o = pin.strobe & pin.read_select;
  assign busy_o = busy;
  assign generator_negative_o = gen_negative;
  assign bias_levels_o = (lines == LINES_ONE) ? `CLCD_BIAS_MUX16 : `CLCD_BIAS_MUX32;
  assign display_on_o = disp_on;
  assign cursor_addr_o = ac;
  assign cursor_on_o = disp_on & cursor_en & ~glyph_mode;
  assign cursor_blink_o = disp_on & blink_en & blink_phase & ~glyph_mode;

endmodule

// file: clcd_core_assertions.sv
`timescale 1ns/1ns
`include "clcd_regs.svh"

module clcd_core_assertions
  import clcd_pkg::*;
#(
  parameter int FRAME_DIV = `CLCD_FRAME_DIV
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire clcd_bus_in_type bus_i,
  input wire logic [7:0] data_o,
  input wire logic data_oe_o,
  input wire logic busy_o,
  input wire logic [2:0] bias_levels_o,
  input wire logic [`CLCD_ROWS-1:0] row_select_o,
  input wire logic frame_tick_o,
  input wire logic [6:0] cursor_addr_o,
  input wire logic cursor_on_o,
  input wire logic cursor_blink_o,
  input wire logic display_on_o,
  input wire logic [6:0] scan_index_o,
  input wire logic [7:0] scan_code_o,
  input wire logic scan_user_glyph_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ********
  // Frame spacing counter
  // ********
  // The first tick after reset has no reference, so only later ones are judged.
  int since;
  logic seen;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      since <= 0;
      seen <= 1'b0;
    end else if (frame_tick_o) begin
      since <= 0;
      seen <= 1'b1;
    end else begin
      since <= since + 1;
    end
  end

  // ********
  // Properties
  // ********
  AST_FRAME_PERIOD: assert property (frame_tick_o && seen |-> since == FRAME_DIV - 1)
    else $error("frame tick spacing wrong");
  AST_ROW_PAIR: assert property (bias_levels_o == 3'h5 && $past(bias_levels_o) == 3'h5
    |-> row_select_o[31:16] == row_select_o[15:0])
    else $error("row outputs not paired in one-line mode");
  AST_BIAS_SET: assert property (bias_levels_o == 3'h5 || bias_levels_o == 3'h6)
    else $error("bias level count illegal");
  AST_OE_CAUSE: assert property ($rose(data_oe_o)
    |-> $past(bus_i.strobe, 2) && $past(bus_i.read_select, 2))
    else $error("data lines driven without a read strobe");
  AST_STATUS_AC: assert property ($rose(data_oe_o) && !bus_i.register_select
    |=> data_o == {$past(busy_o), $past(cursor_addr_o)})
    else $error("status read lacks busy flag or address counter");
  AST_RD_HOLD: assert property (data_oe_o && $past(data_oe_o, 3) |-> $stable(data_o))
    else $error("read data changed during strobe");
  AST_CURSOR_GATE: assert property (cursor_on_o || cursor_blink_o |-> display_on_o)
    else $error("cursor shown with display off");
  AST_GLYPH_COL: assert property (scan_user_glyph_o == (scan_code_o[7:4] == 4'h0))
    else $error("user glyph column flag wrong");
  AST_SCAN_RANGE: assert property (scan_index_o <= 7'h4F)
    else $error("scan index past text memory");
  AST_BUSY_MIN: assert property ($rose(busy_o) |-> busy_o [*2])
    else $error("busy too short");
endmodule

bind clcd_core clcd_core_assertions #(.FRAME_DIV(FRAME_DIV)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .bus_i(bus_i), .data_o(data_o), .data_oe_o(data_oe_o),
  .busy_o(busy_o), .bias_levels_o(bias_levels_o), .row_select_o(row_select_o),
  .frame_tick_o(frame_tick_o), .cursor_addr_o(cursor_addr_o), .cursor_on_o(cursor_on_o),
  .cursor_blink_o(cursor_blink_o), .display_on_o(display_on_o),
  .scan_index_o(scan_index_o), .scan_code_o(scan_code_o),
  .scan_user_glyph_o(scan_user_glyph_o)
);

// file: clcd_host.sv
`timescale 1ns/1ns

module clcd_host
  import clcd_pkg::*;
(
  input wire logic clk_i,
  input wire logic [7:0] data_i,
  output clcd_bus_in_type bus_o
);
  // Released select and data lines float up to their pull-ups.
  localparam clcd_bus_in_type IDLE = '{1'b1, 1'b1, 1'b0, 8'hFF};

  initial bus_o = IDLE;

  // Strobe high and low phases are long enough for the two-stage input sync.
  task automatic access(input logic rs, rw, input logic [7:0] d, output logic [7:0] q);
    @(negedge clk_i);
    bus_o <= '{rs, rw, 1'b1, rw ? 8'hFF : d};
    repeat (5) @(posedge clk_i);
    q = data_i;
    @(negedge clk_i);
    bus_o.strobe <= 1'b0;
    repeat (6) @(negedge clk_i);
    bus_o <= IDLE;
  endtask
endmodule

// file: tb.sv
`timescale 1ns/1ns

module tb;
  import clcd_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  clcd_bus_in_type bus;
  logic [7:0] data_o, scan_code, got_v;
  logic data_oe, busy, gen, cur_on, disp_on;
  logic [2:0] bias;
  logic [6:0] cur_addr;
  logic [15:0] n;
  logic [15:0] exp_q[$];
  int bad_count = 0;
  int tests_run = 0;
  int seed = 67;
  event got_ev;

  initial forever #10 clk_i = ~clk_i;

  clcd_core #(.BUSY_CYCLES(2), .FRAME_DIV(288)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .bus_i(bus), .data_o(data_o), .data_oe_o(data_oe),
    .busy_o(busy), .generator_negative_o(gen), .bias_levels_o(bias), .row_select_o(),
    .frame_tick_o(), .cursor_addr_o(cur_addr), .cursor_on_o(cur_on), .cursor_blink_o(),
    .display_on_o(disp_on), .scan_index_o(), .scan_code_o(scan_code), .scan_user_glyph_o()
  );

  clcd_host host (.clk_i(clk_i), .data_i(data_o), .bus_o(bus));

  // ********
  // Checking
  // ********
  task automatic check(input string nm, input logic [7:0] e, s, m);
    tests_run++;
    if ((s & m) !== (e & m)) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  always @(got_ev) begin
    n = exp_q.pop_front();
    check("read", n[7:0], got_v, n[15:8]);
  end

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ********
  // Bus access
  // ********
  task automatic wr(input logic rs, input logic [7:0] d);
    logic [7:0] x;
    host.access(rs, 1'b0, d, x);
  endtask

  task automatic rd(input logic rs, input logic [7:0] e, m);
    exp_q.push_back({m, e});
    host.access(rs, 1'b1, 8'hFF, got_v);
    ->got_ev;
  endtask

  task automatic idle;
    logic [7:0] x;
    x = 8'h80;
    for (int k = 0; k < 50 && x[7] !== 1'b0; k++) host.access(1'b0, 1'b1, 8'hFF, x);
    if (x[7] !== 1'b0) begin
      bad_count++;
      $display("[FAIL] busy expected 0 seen %h", x[7]);
      close_out();
    end
  endtask

  // ********
  // Scenarios
  // ********
  // Each row: function code, line end address, address after the write.
  logic [21:0] wt[7] = '{{8'h20, 7'h4F, 7'h00}, {8'h25, 7'h27, 7'h40}, {8'h24, 7'h67, 7'h00},
    {8'h29, 7'h13, 7'h20}, {8'h28, 7'h33, 7'h40}, {8'h29, 7'h53, 7'h60},
    {8'h28, 7'h73, 7'h00}};

  initial begin
    logic [7:0] f, d;
    repeat (6) @(negedge clk_i);
    rst_i = 1'b0;
    idle();
    rd(1'b0, 8'h00, 8'hFF);
    check("display", 8'h00, {7'h00, disp_on}, 8'hFF);
    for (int i = 0; i < 7; i++) begin
      f = wt[i][21:14];
      d = 8'($random(seed));
      wr(1'b0, f);
      wr(1'b0, {1'b1, wt[i][13:7]});
      wr(1'b1, d);
      rd(1'b0, {1'b0, wt[i][6:0]}, 8'hFF);
      wr(1'b0, {1'b1, wt[i][13:7]});
      rd(1'b1, d, 8'hFF);
      check("bias", (f[3:2] == 2'h0) ? 8'h05 : 8'h06, {5'h00, bias}, 8'hFF);
      check("generator", {7'h00, f[0]}, {7'h00, gen}, 8'hFF);
    end
    wr(1'b0, 8'h04);
    wr(1'b0, 8'h90);
    wr(1'b1, 8'h5A);
    rd(1'b0, 8'h0F, 8'hFF);
    wr(1'b0, 8'h06);
    wr(1'b0, 8'h01);
    rd(1'b0, 8'h80, 8'h80);
    wr(1'b1, 8'h55);
    idle();
    wr(1'b0, 8'h80);
    rd(1'b1, 8'h20, 8'hFF);
    wr(1'b0, 8'h0E);
    wr(1'b0, 8'h85);
    check("cursor", 8'h85, {cur_on, cur_addr}, 8'hFF);
    wr(1'b0, 8'h45);
    check("cursor", 8'h00, {7'h00, cur_on}, 8'hFF);
    wr(1'b1, 8'hAA);
    rd(1'b0, 8'h06, 8'hFF);
    wr(1'b0, 8'h02);
    rd(1'b0, 8'h00, 8'hFF);
    check("cursor", 8'h80, {cur_on, cur_addr}, 8'hFF);
    rst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    idle();
    repeat (80) @(negedge clk_i) check("scan", 8'h20, scan_code, 8'hFF);
    rd(1'b0, 8'h00, 8'hFF);
    check("bias", 8'h05, {5'h00, bias}, 8'hFF);
    close_out();
  end
endmodule
